// ---- rtl/aop_alarm_out.sv ----
`timescale 1ns/1ps
`include "aop_params.svh"
// How it works
// - Each read of a non-empty queue returns one stored event and removes it.
// - Reading an empty queue returns all-zero event fields.
// - Reading memory retrieval leaves readings intact; only a new scan erases them, through mem_erase.
// - Four alarm lines, each the OR of its assigned channels.
// - Many channels may share a line; one mode setting serves all lines.
// - Factory reset deasserts all lines and keeps the queue.
// - Latch mode asserts on first alarm, holds until clear, scan start, power.
// - Track mode asserts only while a reading stays beyond its limit.
// - Track mode deasserts by itself once the reading returns inside.
// - Software clear works any time and keeps reading memory alarm data.
// - New scan deasserts lines and erases reading memory alarm data.
// - Shared polarity; falling means alarm low, rising means alarm high.
// - Factory reset returns polarity to falling, active low.
// - Changing polarity may toggle the line levels.
// - Clear acts on one selected line or all four.
// - Port and counter alarms evaluate continuously once enabled, scan or not.
// - Port and counter alarm data enter reading memory only during a scan.
// - New scan keeps queued port and counter events.
// - Eight-bit port compared against pattern of one, zero, ignored bits.
// - Equal mode alarms on zero masked XOR; mismatch mode on nonzero.
// - Mask zero bits are excluded from the comparison.
// - Pattern alarm evaluates only when its enable is on.
// - Counter alarms when count reaches upper limit with check enabled.
// - Queue holds 20 events; when full newer events are dropped.
// - Events enter the queue only on the crossing into alarm.
// - Unassigned channels report on alarm line one.
// - Each event holds the reading, channel number and absolute date and time.
module aop_alarm_out
    import aop_pkg::*;
(
    input  wire logic                     clk_sys,          // System clock
    input  wire logic                     reset_n,          // Power-on reset, active low
    input  wire logic [`AOP_PORT_W-1:0]   port0_data,       // Digital port 0 pins
    input  wire logic [`AOP_PORT_W-1:0]   port1_data,       // Digital port 1 pins
    input  wire logic                     port_sample,      // New port sample strobe
    input  wire logic [`AOP_COUNT_W-1:0]  count_value,      // Pulse counter value
    input  wire logic                     count_sample,     // New counter value strobe
    input  wire aop_pattern_cfg_t         port0_cfg,        // Port 0 alarm settings
    input  wire aop_pattern_cfg_t         port1_cfg,        // Port 1 alarm settings
    input  wire aop_count_cfg_t           count_cfg,        // Counter alarm settings
    input  wire logic [`AOP_CHAN_W-1:0]   port0_chan,       // Port 0 channel number
    input  wire logic [`AOP_CHAN_W-1:0]   port1_chan,       // Port 1 channel number
    input  wire logic [`AOP_CHAN_W-1:0]   count_chan,       // Counter channel number
    input  wire logic [`AOP_TIME_W-1:0]   date_time,        // Absolute date and time
    input  wire logic [`AOP_NUM_LINES-1:0] ext_alarm,       // Other channels' alarm levels
    input  wire logic                     mode_set,         // Mode write strobe
    input  wire aop_mode_t                mode_value,       // Latch or track
    input  wire logic                     slope_set,        // Polarity write strobe
    input  wire aop_slope_t               slope_value,      // Falling or rising
    input  wire logic                     clear_one,        // Clear selected line strobe
    input  wire logic [1:0]               clear_sel,        // Line to clear
    input  wire logic                     clear_all,        // Clear all lines strobe
    input  wire logic                     factory_reset,    // Factory reset strobe
    input  wire logic                     queue_clear,      // Clear status strobe
    input  wire logic                     scan_start,       // New scan strobe
    input  wire logic                     scan_running,     // Scan in progress level
    input  wire logic                     queue_read,       // Queue read request strobe
    output aop_event_t                    queue_data,       // Returned event
    output logic                          queue_valid,      // Returned event strobe
    output logic [`AOP_QPTR_W-1:0]        queue_count,      // Entries held
    output logic [`AOP_NUM_LINES-1:0]     alarm_line,       // Alarm output pins
    output logic [`AOP_NUM_LINES-1:0]     alarm_active,     // Alarm state, active high
    output aop_mode_t                     mode,             // Current mode
    output aop_slope_t                    slope,            // Current polarity
    output logic                          mem_alarm_wr,     // Reading memory alarm write
    output logic [`AOP_NUM_SRC-1:0]       mem_alarm_flags,  // Alarm flags to store
    output logic                          mem_erase         // Reading memory erase strobe
);
    localparam int NL = `AOP_NUM_LINES;
    localparam int NS = `AOP_NUM_SRC;
    localparam int QD = `AOP_QUEUE_DEPTH;
    localparam int QW = `AOP_QPTR_W;

    // Masked pattern comparison
    function automatic logic pattern_hit(input logic [`AOP_PORT_W-1:0] value,
                                         input aop_pattern_cfg_t cfg);
        logic [`AOP_PORT_W-1:0] diff;
        diff = (value ^ cfg.compare_reference_pattern) & cfg.compare_care_mask;
        pattern_hit = cfg.enable && (cfg.alarm_on_mismatch ? (diff != 8'h00) : (diff == 8'h00));
    endfunction : pattern_hit

    // Line chosen by a channel's assignment
    function automatic logic [NL-1:0] line_mask(input logic assigned, input logic [1:0] sel);
        logic [1:0] idx;
        idx = assigned ? sel : `AOP_DEFAULT_LINE;
        line_mask = 4'h1 << idx;
    endfunction : line_mask

    // Pin synchronisers
    logic [`AOP_PORT_W-1:0] p0_meta, p0_sync, p1_meta, p1_sync;
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            p0_meta <= 8'h00;
            p0_sync <= 8'h00;
            p1_meta <= 8'h00;
            p1_sync <= 8'h00;
        end else begin
            p0_meta <= port0_data;
            p0_sync <= p0_meta;
            p1_meta <= port1_data;
            p1_sync <= p1_meta;
        end
    end

    // Strobe delayed to match synchroniser latency
    logic [1:0] sample_dly;
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sample_dly <= 2'h0;
        end else begin
            sample_dly <= {sample_dly[0], port_sample};
        end
    end

    // Alarm condition per source, held between samples while its enable stays on
    logic [NS-1:0] cond;
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cond <= 3'h0;
        end else begin
            if (sample_dly[1]) begin
                cond[`AOP_SRC_PORT0] <= pattern_hit(p0_sync, port0_cfg);
                cond[`AOP_SRC_PORT1] <= pattern_hit(p1_sync, port1_cfg);
            end else begin
                cond[`AOP_SRC_PORT0] <= cond[`AOP_SRC_PORT0] & port0_cfg.enable;
                cond[`AOP_SRC_PORT1] <= cond[`AOP_SRC_PORT1] & port1_cfg.enable;
            end
            if (count_sample) begin
                cond[`AOP_SRC_COUNT] <= count_cfg.enable && (count_value >= count_cfg.upper_limit);
            end else begin
                cond[`AOP_SRC_COUNT] <= cond[`AOP_SRC_COUNT] & count_cfg.enable;
            end
        end
    end

    // Crossing detection
    logic [NS-1:0] cond_prev;
    logic [NS-1:0] rise;
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cond_prev <= 3'h0;
        end else begin
            cond_prev <= cond;
        end
    end
    assign rise = cond & ~cond_prev;

    // Per-line OR of assigned sources
    logic [NL-1:0] level_now, rise_now;
    always_comb begin
        level_now = ext_alarm;
        rise_now  = ext_alarm & ~alarm_active;
        if (cond[`AOP_SRC_PORT0]) level_now = level_now | line_mask(port0_cfg.assigned, port0_cfg.line_sel);
        if (cond[`AOP_SRC_PORT1]) level_now = level_now | line_mask(port1_cfg.assigned, port1_cfg.line_sel);
        if (cond[`AOP_SRC_COUNT]) level_now = level_now | line_mask(count_cfg.assigned, count_cfg.line_sel);
        if (rise[`AOP_SRC_PORT0]) rise_now = rise_now | line_mask(port0_cfg.assigned, port0_cfg.line_sel);
        if (rise[`AOP_SRC_PORT1]) rise_now = rise_now | line_mask(port1_cfg.assigned, port1_cfg.line_sel);
        if (rise[`AOP_SRC_COUNT]) rise_now = rise_now | line_mask(count_cfg.assigned, count_cfg.line_sel);
    end

    // Shared mode and polarity settings
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            mode  <= AOP_MODE_LATCH;
            slope <= AOP_SLOPE_FALLING;
        end else begin
            if (factory_reset) begin
                mode  <= AOP_MODE_LATCH;
                slope <= AOP_SLOPE_FALLING;
            end else begin
                if (mode_set) mode <= mode_value;
                if (slope_set) slope <= slope_value;
            end
        end
    end

    // Clear request per line
    logic [NL-1:0] clear_mask;
    always_comb begin
        clear_mask = 4'h0;
        if (clear_one) clear_mask = 4'h1 << clear_sel;
        if (clear_all || factory_reset || scan_start) clear_mask = 4'hF;
    end

    // Alarm state, new alarms win over a clear in the same cycle
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            alarm_active <= 4'h0;
        end else begin
            case (mode)
                AOP_MODE_LATCH: alarm_active <= (alarm_active & ~clear_mask) | rise_now;
                AOP_MODE_TRACK: alarm_active <= level_now & ~(clear_mask & ~rise_now);
                default:        alarm_active <= 4'h0;
            endcase
        end
    end

    // Pin level after polarity; idle high when falling polarity
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            alarm_line <= 4'hF;
        end else begin
            alarm_line <= (slope == AOP_SLOPE_RISING) ? alarm_active : ~alarm_active;
        end
    end

    // Reading memory alarm writes and erase
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            mem_alarm_wr    <= 1'b0;
            mem_alarm_flags <= 3'h0;
            mem_erase       <= 1'b0;
        end else begin
            mem_alarm_wr    <= scan_running && !scan_start && (rise != 3'h0);
            mem_alarm_flags <= rise;
            mem_erase       <= scan_start;
        end
    end

    // Event captured on crossing, lowest source only
    aop_event_t new_event;
    logic       new_valid;
    always_comb begin
        new_event = '0;
        new_valid = 1'b1;
        if (rise[`AOP_SRC_PORT0]) begin
            new_event.reading = {18'h0, p0_sync};
            new_event.channel = port0_chan;
        end else if (rise[`AOP_SRC_PORT1]) begin
            new_event.reading = {18'h0, p1_sync};
            new_event.channel = port1_chan;
        end else if (rise[`AOP_SRC_COUNT]) begin
            new_event.reading = count_value;
            new_event.channel = count_chan;
        end else begin
            new_valid = 1'b0;
        end
        new_event.date_time = date_time;
    end

    // Sources not yet queued, held at zero; of simultaneous crossings only the lowest source is logged
    logic [NS-1:0] pending;
    logic [NS-1:0] take;
    always_comb begin
        take = 3'h0;
        if (new_valid) take = rise & ~(rise - 3'h1);
    end
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pending <= 3'h0;
        end else begin
            pending <= 3'h0;
        end
    end

    // Queue pointers and read state machine
    aop_qstate_t    qstate;
    logic           from_mem;
    logic [QW-1:0]  wr_ptr, rd_ptr, count;
    logic           do_write, do_pop;
    aop_event_t     mem_rd;
    assign do_write = new_valid && (count < 5'(QD)) && !queue_clear;
    assign do_pop   = (qstate == AOP_Q_WAIT) && from_mem; // Pop once the entry is captured

    function automatic logic [QW-1:0] ptr_inc(input logic [QW-1:0] p);
        ptr_inc = (p == 5'(QD - 1)) ? 5'h0 : p + 5'h1;
    endfunction : ptr_inc

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr <= 5'h0;
            rd_ptr <= 5'h0;
            count  <= 5'h0;
        end else if (queue_clear) begin
            wr_ptr <= 5'h0;
            rd_ptr <= 5'h0;
            count  <= 5'h0;
        end else begin
            if (do_write) wr_ptr <= ptr_inc(wr_ptr);
            if (do_pop) rd_ptr <= ptr_inc(rd_ptr);
            count <= count + 5'(do_write) - 5'(do_pop);
        end
    end

    aop_event_mem #(
        .DEPTH (QD),
        .AW    (QW)
    ) u_mem (
        .clk_sys (clk_sys),
        .wr_en   (do_write),
        .wr_addr (wr_ptr),
        .wr_data (new_event),
        .rd_addr (rd_ptr),
        .rd_data (mem_rd)
    );

    // Read answer: pointer held until the registered entry is captured
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            qstate      <= AOP_Q_IDLE;
            from_mem    <= 1'b0;
            queue_valid <= 1'b0;
            queue_data  <= '0;
        end else begin
            queue_valid <= 1'b0;
            case (qstate)
                AOP_Q_IDLE: begin
                    if (queue_read) begin
                        from_mem <= (count != 5'h0);
                        qstate   <= AOP_Q_READ;
                    end
                end
                AOP_Q_READ: begin
                    qstate <= AOP_Q_WAIT;
                end
                AOP_Q_WAIT: begin
                    queue_valid <= 1'b1;
                    queue_data  <= from_mem ? mem_rd : '0;
                    qstate      <= AOP_Q_IDLE;
                end
                default: qstate <= AOP_Q_IDLE;
            endcase
        end
    end

    // Fill level reported
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            queue_count <= 5'h0;
        end else begin
            queue_count <= count;
        end
    end
endmodule : aop_alarm_out

// ---- rtl/aop_params.svh ----
`ifndef AOP_PARAMS_SVH
`define AOP_PARAMS_SVH
`define AOP_NUM_LINES      4
`define AOP_PORT_W         8
`define AOP_COUNT_W        26
`define AOP_QUEUE_DEPTH    20
`define AOP_QPTR_W         5
`define AOP_CHAN_W         8
`define AOP_TIME_W         32
`define AOP_READING_W      26
`define AOP_LINE_SEL_W     2
`define AOP_DEFAULT_LINE   2'h0
`define AOP_NUM_SRC        3
`define AOP_SRC_PORT0      0
`define AOP_SRC_PORT1      1
`define AOP_SRC_COUNT      2
`endif

// ---- rtl/aop_pkg.sv ----
`include "aop_params.svh"
package aop_pkg;
    typedef enum logic [0:0] {
        AOP_MODE_LATCH = 1'b0,
        AOP_MODE_TRACK = 1'b1
    } aop_mode_t;

    typedef enum logic [0:0] {
        AOP_SLOPE_FALLING = 1'b0,
        AOP_SLOPE_RISING  = 1'b1
    } aop_slope_t;

    typedef enum logic [1:0] {
        AOP_Q_IDLE  = 2'b00,
        AOP_Q_READ  = 2'b01,
        AOP_Q_WAIT  = 2'b10
    } aop_qstate_t;

    // One alarm queue entry
    typedef struct packed {
        logic [`AOP_READING_W-1:0] reading;
        logic [`AOP_CHAN_W-1:0]    channel;
        logic [`AOP_TIME_W-1:0]    date_time;
    } aop_event_t;

    // Pattern alarm settings of one digital port
    typedef struct packed {
        logic                   enable;
        logic                   alarm_on_mismatch;
        logic [`AOP_PORT_W-1:0] compare_reference_pattern;
        logic [`AOP_PORT_W-1:0] compare_care_mask;
        logic                   assigned;
        logic [1:0]             line_sel;
    } aop_pattern_cfg_t;

    // Counter alarm settings
    typedef struct packed {
        logic                    enable;
        logic [`AOP_COUNT_W-1:0] upper_limit;
        logic                    assigned;
        logic [1:0]              line_sel;
    } aop_count_cfg_t;
endpackage : aop_pkg

// ---- rtl/aop_event_mem.sv ----
`timescale 1ns/1ps
`include "aop_params.svh"
// Alarm queue storage with registered read data
module aop_event_mem
    import aop_pkg::*;
#(
    parameter int DEPTH = `AOP_QUEUE_DEPTH,
    parameter int AW    = `AOP_QPTR_W
) (
    input  wire logic          clk_sys,  // System clock
    input  wire logic          wr_en,    // Write strobe
    input  wire logic [AW-1:0] wr_addr,  // Write index
    input  wire aop_event_t    wr_data,  // Write entry
    input  wire logic [AW-1:0] rd_addr,  // Read index
    output aop_event_t         rd_data   // Registered entry
);
    aop_event_t mem [DEPTH];

    // Storage write
    always_ff @(posedge clk_sys) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Registered read
    always_ff @(posedge clk_sys) begin
        rd_data <= mem[rd_addr];
    end
endmodule : aop_event_mem

// ---- tb/aop_alarm_out_sva.sv ----
`timescale 1ns/1ps
`include "aop_params.svh"
// Timing and output relations of the alarm block
module aop_alarm_out_sva
    import aop_pkg::*;
(
    input wire logic                      clk_sys,       // System clock
    input wire logic                      reset_n,       // Reset, active low
    input wire logic [`AOP_COUNT_W-1:0]   count_value,   // Counter value
    input wire logic                      count_sample,  // Counter strobe
    input wire aop_count_cfg_t            count_cfg,     // Counter settings
    input wire logic [`AOP_NUM_LINES-1:0] ext_alarm,     // Other channels
    input wire logic                      slope_set,     // Polarity write
    input wire aop_slope_t                slope_value,   // Polarity value
    input wire logic                      clear_one,     // Clear one line
    input wire logic                      clear_all,     // Clear all lines
    input wire logic                      factory_reset, // Factory reset
    input wire logic                      scan_start,    // New scan
    input wire logic                      scan_running,  // Scan level
    input wire logic                      queue_read,    // Queue request
    input wire aop_event_t                queue_data,    // Returned event
    input wire logic                      queue_valid,   // Event strobe
    input wire logic [`AOP_QPTR_W-1:0]    queue_count,   // Fill level
    input wire logic [`AOP_NUM_LINES-1:0] alarm_line,    // Pin levels
    input wire logic [`AOP_NUM_LINES-1:0] alarm_active,  // Alarm state
    input wire aop_mode_t                 mode,          // Mode
    input wire aop_slope_t                slope,         // Polarity
    input wire logic                      mem_alarm_wr,  // Memory write
    input wire logic                      mem_erase      // Memory erase
);
    logic any_clear;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    // Any cause that may drop a latched line
    assign any_clear = clear_one | clear_all | factory_reset | scan_start;

    queue_answer_a: assert property (queue_valid |-> $past(queue_read, 3))
        else $error("queue answer without request");
    empty_zero_a: assert property (queue_valid && $past(queue_count, 3) == 5'h00 && $past(queue_count, 4) == 5'h00
        |-> queue_data == '0) else $error("empty queue answer not zero");
    queue_cap_a: assert property (queue_count <= 5'h14) else $error("queue above capacity");
    line_pol_a: assert property ($stable(alarm_active) && $stable(slope) && $past(slope, 2) == slope
        |-> alarm_line == ((slope == AOP_SLOPE_RISING) ? alarm_active : ~alarm_active))
        else $error("line level disagrees with polarity");
    factory_def_a: assert property (factory_reset |=> slope == AOP_SLOPE_FALLING && mode == AOP_MODE_LATCH)
        else $error("factory reset left polarity or mode");
    slope_set_a: assert property (slope_set && !factory_reset |=> slope == $past(slope_value))
        else $error("polarity write lost");
    factory_clear_a: assert property (factory_reset && !count_sample && ext_alarm == $past(ext_alarm)
        |=> alarm_active == 4'h0) else $error("factory reset kept a line");
    clear_all_a: assert property (clear_all && mode == AOP_MODE_LATCH && !count_sample && $stable(ext_alarm)
        |=> alarm_active == 4'h0) else $error("clear all kept a line");
    scan_erase_a: assert property (scan_start |=> mem_erase) else $error("new scan without erase");
    mem_wr_scan_a: assert property (mem_alarm_wr |-> $past(scan_running) || $past(scan_running, 2))
        else $error("memory alarm write outside scan");
    latch_hold_a: assert property (mode == AOP_MODE_LATCH && $past(mode) == AOP_MODE_LATCH
        && (|(~alarm_active & $past(alarm_active))) |-> $past(any_clear) || $past(any_clear, 2))
        else $error("latched line dropped without clear");
    count_hit_a: assert property (count_sample && count_cfg.enable && mode == AOP_MODE_TRACK
        && count_value >= count_cfg.upper_limit && !scan_start && !factory_reset
        |-> ##2 alarm_active[count_cfg.assigned ? count_cfg.line_sel : 2'h0]) else $error("counter limit missed");
endmodule : aop_alarm_out_sva

bind aop_alarm_out aop_alarm_out_sva u_sva (.*);

// ---- tb/aop_lamp_bank.sv ----
`timescale 1ns/1ps
// Alarm lamp bank on the four output pins
module aop_lamp_bank
    import aop_pkg::*;
(
    input  wire logic [3:0] alarm_line, // Pins from the block
    input  wire aop_slope_t slope,      // Polarity chosen by the host
    output logic [3:0]      lit         // Lamp on per line
);
    // Low pin means alarm unless rising polarity is chosen
    assign lit = (slope == AOP_SLOPE_RISING) ? alarm_line : ~alarm_line;
endmodule : aop_lamp_bank

// ---- tb/tb.sv ----
`timescale 1ns/1ps
module tb
    import aop_pkg::*;
;
    localparam logic [31:0] STAMP = 32'h5A5A0001;
    logic             clk_sys = 1'b0, reset_n = 1'b0, port_sample = 1'b0, count_sample = 1'b0, mode_set = 1'b0;
    logic             slope_set = 1'b0, clear_one = 1'b0, clear_all = 1'b0, factory_reset = 1'b0;
    logic             queue_clear = 1'b0, scan_start = 1'b0, scan_running = 1'b0, queue_read = 1'b0;
    logic [7:0]       port0_data = 8'h00, port1_data = 8'h00;
    logic [25:0]      count_value = 26'h0;
    aop_pattern_cfg_t port0_cfg = '0, port1_cfg = '0;
    aop_count_cfg_t   count_cfg = '0;
    logic [3:0]       ext_alarm = 4'h0;
    aop_mode_t        mode_value = AOP_MODE_LATCH;
    aop_slope_t       slope_value = AOP_SLOPE_FALLING;
    logic [1:0]       clear_sel = 2'h0;
    aop_event_t       queue_data, ev;
    logic             queue_valid, mem_alarm_wr, mem_erase;
    logic [4:0]       queue_count;
    logic [3:0]       alarm_line, alarm_active, lit;
    aop_mode_t        mode;
    aop_slope_t       slope;
    logic [2:0]       mem_alarm_flags, wr_flags = 3'h0;
    int               miscompares = 0, cmp_count = 0;

    always #2 clk_sys = ~clk_sys;
    // Collect flags written to reading memory
    always @(posedge clk_sys) if (mem_alarm_wr) wr_flags <= wr_flags | mem_alarm_flags;

    aop_alarm_out uut (.port0_chan(8'h01), .port1_chan(8'h02), .count_chan(8'h03), .date_time(STAMP), .*);
    aop_lamp_bank u_lamps (.alarm_line(alarm_line), .slope(slope), .lit(lit));

    task automatic report_and_stop();
        $display("comparisons=%0d mismatches=%0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : report_and_stop
    task automatic check(input logic [95:0] seen, input logic [95:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : tick
    task automatic port_samp(input logic [7:0] p0, input logic [7:0] p1);
        port0_data = p0;
        port1_data = p1;
        tick(3);
        port_sample = 1'b1;
        tick(1);
        port_sample = 1'b0;
        tick(5);
    endtask : port_samp
    task automatic cnt_samp(input logic [25:0] v);
        count_value = v;
        count_sample = 1'b1;
        tick(1);
        count_sample = 1'b0;
        tick(4);
    endtask : cnt_samp
    // One queue request, bounded wait for the answer
    task automatic qread(output aop_event_t e);
        queue_read = 1'b1;
        tick(1);
        queue_read = 1'b0;
        for (int i = 0; i < 8 && queue_valid !== 1'b1; i++) tick(1);
        if (queue_valid !== 1'b1) begin
            miscompares++;
            report_and_stop();
        end
        e = queue_data;
        tick(2);
    endtask : qread

    task automatic t_reset();
        check({alarm_line, mode, slope, queue_count}, {4'hF, AOP_MODE_LATCH, AOP_SLOPE_FALLING, 5'h00});
        qread(ev);
        check(ev, '0);
    endtask : t_reset
    task automatic t_pattern();
        port0_cfg = '{1'b0, 1'b0, 8'h80, 8'hF0, 1'b0, 2'h3};
        port_samp(8'h85, 8'h00);
        check(alarm_active, 4'h0);
        port0_cfg.enable = 1'b1;
        port_samp(8'h92, 8'h00);
        check(alarm_active, 4'h0);
        port_samp(8'h8A, 8'h00);
        check({alarm_active, alarm_line, lit}, {4'h1, 4'hE, 4'h1});
        port_samp(8'h92, 8'h00);
        check({alarm_active, queue_count}, {4'h1, 5'h01});
        port1_cfg = '{1'b1, 1'b1, 8'h55, 8'hFF, 1'b1, 2'h1};
        port_samp(8'h92, 8'h55);
        check(alarm_active, 4'h1);
        port_samp(8'h92, 8'h54);
        check({alarm_active, queue_count}, {4'h3, 5'h02});
        qread(ev);
        check(ev, {26'h8A, 8'h01, STAMP});
        qread(ev);
        check({ev, queue_count}, {26'h54, 8'h02, STAMP, 5'h00});
        clear_sel = 2'h1;
        clear_one = 1'b1;
        tick(1);
        clear_one = 1'b0;
        tick(2);
        check(alarm_active, 4'h1);
        clear_all = 1'b1;
        tick(1);
        clear_all = 1'b0;
        check(mem_erase, 1'b0);
        tick(2);
        check(alarm_active, 4'h0);
        port0_cfg.enable = 1'b0;
        port1_cfg.enable = 1'b0;
    endtask : t_pattern
    task automatic t_track();
        mode_value = AOP_MODE_TRACK;
        mode_set = 1'b1;
        tick(1);
        mode_set = 1'b0;
        count_cfg = '{1'b1, 26'h100, 1'b1, 2'h2};
        cnt_samp(26'h0FF);
        check(alarm_active, 4'h0);
        cnt_samp(26'h100);
        check({alarm_active, queue_count}, {4'h4, 5'h01});
        ext_alarm = 4'h4;
        tick(3);
        cnt_samp(26'h0FF);
        check(alarm_active, 4'h4);
        ext_alarm = 4'h0;
        tick(3);
        check(alarm_active, 4'h0);
    endtask : t_track
    task automatic t_slope();
        cnt_samp(26'h200);
        slope_value = AOP_SLOPE_RISING;
        slope_set = 1'b1;
        tick(1);
        slope_set = 1'b0;
        tick(2);
        check({alarm_line, lit}, {4'h4, 4'h4});
        factory_reset = 1'b1;
        tick(1);
        factory_reset = 1'b0;
        tick(2);
        check({alarm_active, alarm_line, slope, mode, queue_count},
              {4'h0, 4'hF, AOP_SLOPE_FALLING, AOP_MODE_LATCH, 5'h02});
    endtask : t_slope
    task automatic t_scan();
        cnt_samp(26'h0);
        cnt_samp(26'h100);
        check({wr_flags, alarm_active}, {3'h0, 4'h4});
        cnt_samp(26'h0);
        scan_running = 1'b1;
        cnt_samp(26'h100);
        check(wr_flags, 3'h4);
        scan_start = 1'b1;
        tick(1);
        check(mem_erase, 1'b1);
        scan_start = 1'b0;
        tick(2);
        check({alarm_active, queue_count}, {4'h0, 5'h04});
        scan_running = 1'b0;
    endtask : t_scan
    task automatic t_full();
        queue_clear = 1'b1;
        tick(1);
        queue_clear = 1'b0;
        tick(2);
        for (int i = 0; i < 22; i++) begin
            cnt_samp(26'h0);
            cnt_samp(26'h100 + 26'(i));
        end
        check(queue_count, 5'h14);
        qread(ev);
        check(ev, {26'h100, 8'h03, STAMP});
    endtask : t_full

    initial begin
        tick(5);
        reset_n = 1'b1;
        tick(1);
        t_reset();
        t_pattern();
        t_track();
        t_slope();
        t_scan();
        t_full();
        report_and_stop();
    end
endmodule : tb
